/* irpc_codec.sv */
// Top of the infrared pulse codec between NU USARTs and its TX/RX pins.
// Assumes USART mode fields, TX level and 16x oversample tick arrive synchronous.
`timescale 1ns/1ps
module irpc_codec #(
    parameter int unsigned NU = irpc_pkg::N_USART
) (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_n_i,
    input  wire irpc_pkg::irpc_bus_s  bus_i,
    output logic [7:0]                rdata_o,
    input  wire logic [2*NU-1:0]      communication_mode_select_i,
    input  wire logic [NU-1:0]        usart_tx_i,
    input  wire logic                 ovs_tick_i,
    input  wire logic [3:0]           ovs_phase_i,
    input  wire logic [7:0]           event_channel_n_i,
    input  wire logic                 rx_pin_i,
    output logic                      tx_pin_o,
    output logic [NU-1:0]             usart_rx_o,
    output logic                      active_o
);
    import irpc_pkg::*;

    irpc_cfg_s  cfg_reg;
    logic [7:0] rdata_reg;
    logic [NU-1:0] ir_sel;
    logic       active;
    logic       tx_sel;
    logic       pulse;
    logic       rx_src;
    logic       rx_pulse;
    logic       filt;
    logic       short_ok;
    logic [7:0] hi_reg;
    logic       rx_dec_reg;
    logic       tx_pin_reg;
    logic [NU-1:0] rx_out_reg;
    logic       active_reg;

    genvar g;
    generate
        for (g = 0; g < NU; g++) begin : g_sel
            assign ir_sel[g] = communication_mode_select_i[2*g +: 2] == COMM_MODE_IR;
        end
    endgenerate

    assign active = |ir_sel;

    always_comb begin
        tx_sel = 1'b1;
        for (int i = 0; i < NU; i++) begin
            if (ir_sel[i]) begin
                tx_sel = usart_tx_i[i];
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            cfg_reg <= '{ev_sel: RST_REG, txpl: RST_REG, rxfl: RST_REG};
        end else if (bus_i.wr) begin
            case (bus_i.addr)
                ADDR_EVCH:  cfg_reg.ev_sel <= {4'h0, bus_i.wdata[3:0]};
                ADDR_TXPL:  cfg_reg.txpl  <= bus_i.wdata;
                ADDR_RXFL:  cfg_reg.rxfl  <= bus_i.wdata;
                default:    cfg_reg       <= cfg_reg;
            endcase
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rdata_reg <= 8'h00;
        end else if (bus_i.rd) begin
            case (bus_i.addr)
                ADDR_EVCH:  rdata_reg <= cfg_reg.ev_sel;
                ADDR_TXPL:  rdata_reg <= cfg_reg.txpl;
                ADDR_RXFL:  rdata_reg <= cfg_reg.rxfl;
                default:    rdata_reg <= 8'h00;
            endcase
        end else begin
            rdata_reg <= 8'h00;
        end
    end

    irpc_tx_shaper u_tx (
        .core_clk_i  (core_clk_i),
        .rst_n_i     (rst_n_i),
        .active_i    (active),
        .txpl_i      (cfg_reg.txpl),
        .tx_bit_i    (tx_sel),
        .ovs_tick_i  (ovs_tick_i),
        .ovs_phase_i (ovs_phase_i),
        .pulse_o     (pulse)
    );

    // Reserved select codes fall back to the pin
    assign rx_src = cfg_reg.ev_sel[EV_EN_BIT] ?
                    event_channel_n_i[cfg_reg.ev_sel[2:0]] : rx_pin_i;
    assign rx_pulse = !rx_src;

    irpc_rx_filter u_rx (
        .core_clk_i (core_clk_i),
        .rst_n_i    (rst_n_i),
        .rxfl_i     (cfg_reg.rxfl),
        .raw_i      (rx_pulse),
        .filt_o     (filt)
    );

    // Minimum width is the filter count plus one clock; high runs shorter are dropped
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !filt) begin
            hi_reg <= 8'h00;
        end else if (hi_reg != 8'hFF) begin
            hi_reg <= hi_reg + 8'h01;
        end
    end

    assign short_ok = filt && (hi_reg >= cfg_reg.rxfl);

    // Decoded zero is held until the OVS_LAST (phase 15) tick of the baud period
    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            rx_dec_reg <= 1'b1;
        end else if (short_ok) begin
            rx_dec_reg <= 1'b0;
        end else if (ovs_tick_i && ovs_phase_i == OVS_LAST) begin
            rx_dec_reg <= 1'b1;
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            tx_pin_reg <= 1'b1;
            rx_out_reg <= '1;
            active_reg <= 1'b0;
        end else begin
            active_reg <= active;
            if (!active) begin
                tx_pin_reg <= tx_sel;
                rx_out_reg <= {NU{rx_pin_i}};
            end else if (cfg_reg.txpl == TXPL_BYPASS) begin
                tx_pin_reg <= tx_sel;
                rx_out_reg <= (ir_sel & {NU{rx_src}}) | ~ir_sel;
            end else begin
                tx_pin_reg <= !pulse;
                rx_out_reg <= (ir_sel & {NU{rx_dec_reg}}) | ~ir_sel;
            end
        end
    end

    assign tx_pin_o   = tx_pin_reg;
    assign usart_rx_o = rx_out_reg;
    assign active_o   = active_reg;
    assign rdata_o    = rdata_reg;

    // Pass-through skips both shaper and filter, in each direction
    bypass_tx_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (active && cfg_reg.txpl == TXPL_BYPASS) |=> tx_pin_reg == $past(tx_sel))
        else $error("bypass tx altered");
    bypass_rx_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (active && cfg_reg.txpl == TXPL_BYPASS && !cfg_reg.ev_sel[EV_EN_BIT] && ir_sel[0])
        |=> usart_rx_o[0] == $past(rx_pin_i))
        else $error("bypass rx altered");
    tx_invert_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (active && cfg_reg.txpl != TXPL_BYPASS) |=> tx_pin_reg == !$past(pulse))
        else $error("tx pin not inverted pulse");
    ev_sel_rd_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (bus_i.rd && bus_i.addr == ADDR_EVCH) |=> rdata_reg[7:4] == 4'h0)
        else $error("reserved select bits not zero");
    ev_sel_wr_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (bus_i.wr && bus_i.addr == ADDR_EVCH) |=> cfg_reg.ev_sel[7:4] == 4'h0)
        else $error("reserved select bits stored");
    active_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        active_reg == $past(|ir_sel))
        else $error("active flag wrong");
    idle_pass_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !active |=> tx_pin_reg == $past(tx_sel))
        else $error("codec acted while idle");
    // With no infrared user the receive pin reaches every USART untouched
    idle_rx_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        !active |=> usart_rx_o == {NU{$past(rx_pin_i)}})
        else $error("idle rx altered");
    ev_rx_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (active && cfg_reg.txpl == TXPL_BYPASS && cfg_reg.ev_sel[EV_EN_BIT] && ir_sel[0])
        |=> usart_rx_o[0] == $past(event_channel_n_i[cfg_reg.ev_sel[2:0]]))
        else $error("event input not routed");
    dec_zero_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        short_ok |=> !rx_dec_reg)
        else $error("wide pulse not decoded as zero");
endmodule : irpc_codec

/* irpc_pkg.sv */
// Constants, register map and carrier types for the infrared pulse codec.
// Assumes a single core clock and a plain register port; offsets are byte indexes.
// Summary of operation
// - Codec active whenever any USART selects infrared
// - Pin levels are inverse of infrared pulse
// - Event input replaces the RX pin entirely
// - Pulse length zero gives 3/16 bit
// - Values 1..254 give that many clocks
// - Fixed pulses start on baud clock rise
// - Value 255 passes TX and RX unchanged
// - Pass-through supports half-duplex, loop-back, events
// - Settings inert unless infrared mode selected
// - Receive filter zero means no filtering
// - Filter x needs x+1 equal samples
// - Short pulses decode as logical one
// - Event select 0000 none, 1nnn channel
// - Mode field value 10 means infrared
package irpc_pkg;
    localparam int unsigned CLK_HZ        = 25000000;
    localparam int unsigned N_USART       = 2;
    localparam int unsigned N_EVCH        = 8;
    localparam logic [1:0]  ADDR_EVCH     = 2'h0;
    localparam logic [1:0]  ADDR_TXPL     = 2'h1;
    localparam logic [1:0]  ADDR_RXFL     = 2'h2;
    localparam logic [7:0]  RST_REG       = 8'h00;
    localparam logic [1:0]  COMM_MODE_IR  = 2'h2;
    localparam logic [7:0]  TXPL_BAUD     = 8'h00;
    localparam logic [7:0]  TXPL_BYPASS   = 8'hFF;
    localparam logic [7:0]  RXFL_OFF      = 8'h00;
    localparam int unsigned EV_EN_BIT     = 3;
    localparam int unsigned SIXTEENTHS    = 3;
    localparam logic [3:0]  OVS_LAST      = 4'hF;
    localparam logic [3:0]  OVS_PULSE_END = 4'(SIXTEENTHS);

    typedef struct packed {
        logic [1:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } irpc_bus_s;

    typedef struct packed {
        logic [7:0] ev_sel;
        logic [7:0] txpl;
        logic [7:0] rxfl;
    } irpc_cfg_s;
endpackage : irpc_pkg

/* irpc_tx_shaper.sv */
// Transmit pulse shaper: turns a USART TX level into an infrared pulse.
// Assumes ovs_tick_i marks the 16x oversample clock, phase 0 at bit start.
`timescale 1ns/1ps
module irpc_tx_shaper (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic                 active_i,
    input  wire logic [7:0]           txpl_i,
    input  wire logic                 tx_bit_i,
    input  wire logic                 ovs_tick_i,
    input  wire logic [3:0]           ovs_phase_i,
    output logic                      pulse_o
);
    import irpc_pkg::*;

    logic [7:0] cnt_reg;
    logic       pulse_reg;
    logic       bit_start;

    // A zero bit begins at phase 0 of a baud period
    assign bit_start = ovs_tick_i && (ovs_phase_i == 4'h0) && !tx_bit_i;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i || !active_i) begin
            pulse_reg <= 1'b0;
            cnt_reg   <= 8'h00;
        end else if (txpl_i == TXPL_BAUD) begin
            if (bit_start) begin
                pulse_reg <= 1'b1;
            end else if (ovs_tick_i && ovs_phase_i == OVS_PULSE_END) begin
                pulse_reg <= 1'b0;
            end
        end else if (txpl_i != TXPL_BYPASS) begin
            if (bit_start) begin
                pulse_reg <= 1'b1;
                cnt_reg   <= txpl_i - 8'h01;
            end else if (cnt_reg != 8'h00) begin
                cnt_reg <= cnt_reg - 8'h01;
            end else begin
                pulse_reg <= 1'b0;
            end
        end else begin
            pulse_reg <= !tx_bit_i;
        end
    end

    assign pulse_o = pulse_reg;

    // A one-clock pulse rises and falls on successive edges
    sequence one_clk_pulse_s;
        pulse_reg ##1 !pulse_reg;
    endsequence
    fixed_len_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        (active_i && txpl_i == 8'h01 && bit_start && !pulse_reg) |=> one_clk_pulse_s)
        else $error("fixed pulse length wrong");
endmodule : irpc_tx_shaper

/* irpc_rx_filter.sv */
// Receive sample filter: a level is accepted after x+1 equal samples.
// Assumes input is already synchronous to the core clock.
`timescale 1ns/1ps
module irpc_rx_filter (
    input  wire logic                 core_clk_i,
    input  wire logic                 rst_n_i,
    input  wire logic [7:0]           rxfl_i,
    input  wire logic                 raw_i,
    output logic                      filt_o
);
    import irpc_pkg::*;

    logic [7:0] run_reg;
    logic       prev_reg;
    logic       held_reg;

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            prev_reg <= 1'b0;
            run_reg  <= 8'h00;
        end else begin
            prev_reg <= raw_i;
            if (raw_i != prev_reg) begin
                run_reg <= 8'h00;
            end else if (run_reg != 8'hFF) begin
                run_reg <= run_reg + 8'h01;
            end
        end
    end

    always_ff @(posedge core_clk_i) begin
        if (!rst_n_i) begin
            held_reg <= 1'b0;
        end else if (rxfl_i == RXFL_OFF) begin
            held_reg <= raw_i;
        end else if (raw_i == prev_reg && run_reg >= rxfl_i - 8'h01) begin
            held_reg <= raw_i;
        end
    end

    // Zero filter must follow the input with a single-cycle lag
    assign filt_o = held_reg;

    // Filter held off for two edges in a row
    sequence filter_off_s;
        (rxfl_i == RXFL_OFF) ##1 (rxfl_i == RXFL_OFF);
    endsequence
    no_filter_a: assert property (@(posedge core_clk_i) disable iff (!rst_n_i)
        filter_off_s |-> held_reg == $past(raw_i))
        else $error("unfiltered path lagged");
endmodule : irpc_rx_filter

/* irpc_ir_xcvr.sv */
// Infrared transceiver model at the codec's TX/RX pins.
// Assumes a low pin level means light; the RX line idles high between pulses.
`timescale 1ns/1ps
module irpc_ir_xcvr (
    input  wire logic        core_clk_i,
    input  wire logic        tx_pin_i,
    input  wire logic        send_i,
    input  wire logic [8:0]  width_i,
    output logic             rx_pin_o,
    output logic [15:0]      last_width_o,
    output logic [7:0]       pulse_cnt_o
);
    logic [15:0] run_reg = 16'h0;
    logic [8:0]  left_reg = 9'h0;
    logic [15:0] lw_reg = 16'h0;
    logic [7:0]  pc_reg = 8'h0;
    assign last_width_o = lw_reg;
    assign pulse_cnt_o  = pc_reg;
    // Light is a low pin, so the low run is the pulse
    always @(posedge core_clk_i) begin
        if (!tx_pin_i) begin
            run_reg <= run_reg + 16'h1;
        end else if (run_reg != 16'h0) begin
            lw_reg <= run_reg;
            pc_reg <= pc_reg + 8'h1;
            run_reg <= 16'h0;
        end
    end
    always @(posedge core_clk_i) begin
        if (send_i) begin
            left_reg <= width_i;
        end else if (left_reg != 9'h0) begin
            left_reg <= left_reg - 9'h1;
        end
    end
    // Received light drives the RX line low
    assign rx_pin_o = (left_reg == 9'h0);
endmodule : irpc_ir_xcvr

/* tb_infrared_pulse_codec.sv */
// Self-checking bench for the infrared pulse codec with a transceiver model.
// Assumes the codec contract: registered pins, rdata one cycle after a read.
`timescale 1ns/1ps
module tb_infrared_pulse_codec;
    import irpc_pkg::*;
    localparam int D = 20;
    logic core_clk_i, rst_n_i, rx_pin_i, tx_pin_o, active_o, tx_next, send;
    logic        ovs_tick_i = 1'b0;
    logic [8:0]  width;
    irpc_bus_s   bus_i;
    logic [7:0]  rdata_o, event_channel_n_i, pcnt, pl;
    logic [3:0]  communication_mode_select_i;
    logic [3:0]  ovs_phase_i = 4'h0;
    logic [1:0]  usart_tx_i = 2'b11;
    logic [1:0]  usart_rx_o;
    logic [15:0] lastw;
    int          cnt, zc, seed, mismatches, total_checks;
    irpc_codec #(.NU(2)) uut (.core_clk_i, .rst_n_i, .bus_i, .rdata_o,
        .communication_mode_select_i, .usart_tx_i, .ovs_tick_i, .ovs_phase_i,
        .event_channel_n_i, .rx_pin_i, .tx_pin_o, .usart_rx_o, .active_o);
    irpc_ir_xcvr xcvr (.core_clk_i, .tx_pin_i(tx_pin_o), .send_i(send), .width_i(width),
        .rx_pin_o(rx_pin_i), .last_width_o(lastw), .pulse_cnt_o(pcnt));
    initial begin
        core_clk_i = 1'b0;
        forever #20 core_clk_i = ~core_clk_i;
    end
    // Baud clock model: USART bits change only at the phase 0 tick
    always @(posedge core_clk_i) begin
        cnt <= (cnt == D - 1) ? 0 : cnt + 1;
        ovs_tick_i <= (cnt == D - 1);
        zc <= zc + int'(!usart_rx_o[0]);
        if (cnt == D - 1) begin
            ovs_phase_i <= ovs_phase_i + 4'h1;
            if (ovs_phase_i == 4'hF) usart_tx_i <= {1'b1, tx_next};
        end
    end
    task chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp) begin
            mismatches++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge core_clk_i) bus_i <= '{a, d, 1'b1, 1'b0};
        @(posedge core_clk_i) bus_i.wr <= 1'b0;
    endtask : wr
    task rd(input logic [1:0] a, input logic [7:0] e);
        @(posedge core_clk_i) bus_i <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge core_clk_i) bus_i.rd <= 1'b0;
        #1 chk(rdata_o, e);
    endtask : rd
    // Expected low run on the TX pin for one zero bit at a pulse setting
    function automatic logic [15:0] exp_width(input logic [7:0] p);
        if (p == TXPL_BAUD) return 16'(SIXTEENTHS * D);
        if (p == TXPL_BYPASS) return 16'(16 * D);
        return {8'h00, p};
    endfunction : exp_width
    // One zero bit, then idle; n pulses are expected at the transceiver
    task tx_try(input logic [7:0] p, input logic [7:0] n);
        logic [7:0]  p0;
        logic [15:0] w0;
        wr(ADDR_TXPL, p);
        p0 = pcnt;
        w0 = lastw;
        @(posedge core_clk_i) tx_next <= 1'b0;
        repeat (16 * D) @(posedge core_clk_i);
        tx_next <= 1'b1;
        repeat (32 * D) @(posedge core_clk_i);
        chk(pcnt - p0, n);
        chk(lastw, (n == 8'h00) ? w0 : exp_width(p));
    endtask : tx_try
    task rx_try(input logic ev, input logic [8:0] w, input logic exp);
        int z0;
        z0 = zc;
        @(posedge core_clk_i);
        if (ev) begin
            event_channel_n_i <= 8'hF7;
            repeat (w) @(posedge core_clk_i);
            event_channel_n_i <= 8'hFF;
        end else begin
            send <= 1'b1;
            width <= w;
            @(posedge core_clk_i) send <= 1'b0;
        end
        repeat (20 * D) @(posedge core_clk_i);
        chk(zc != z0, exp);
        chk(usart_rx_o[1], 1'b1);
    endtask : rx_try
    task end_of_test;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : end_of_test
    initial begin
        #1600000;
        mismatches++;
        end_of_test;
    end
    initial begin
        {rst_n_i, send, width} = '0;
        {bus_i, communication_mode_select_i} = '0;
        tx_next = 1'b1;
        event_channel_n_i = 8'hFF;
        seed = 32'h8deb;
        repeat (20) @(posedge core_clk_i);
        rst_n_i <= 1'b1;
        for (int a = 0; a < 4; a++) rd(2'(a), RST_REG);
        wr(ADDR_EVCH, 8'hFF);
        rd(ADDR_EVCH, 8'h0F);
        wr(2'h3, 8'h5A);
        rd(2'h3, 8'h00);
        wr(ADDR_EVCH, 8'h00);
        for (int m = 0; m < 4; m++) begin
            communication_mode_select_i <= 4'(m);
            repeat (4) @(posedge core_clk_i);
            chk(active_o, m == 2);
        end
        // Only USART 0 is put in infrared mode
        communication_mode_select_i <= 4'h2;
        tx_try(TXPL_BAUD, 8'h01);
        tx_try(8'h01, 8'h01);
        tx_try(8'hFE, 8'h01);
        for (int i = 0; i < 3; i++) begin
            pl = 8'(1 + ($unsigned($random(seed)) % 254));
            tx_try(pl, 8'h01);
        end
        tx_try(TXPL_BYPASS, 8'h01);
        // Pass-through must ignore the filter and carry the event input
        wr(ADDR_RXFL, 8'h0A);
        rx_try(1'b0, 9'd2, 1'b1);
        wr(ADDR_EVCH, 8'h0B);
        rx_try(1'b1, 9'd30, 1'b1);
        wr(ADDR_EVCH, 8'h00);
        wr(ADDR_TXPL, TXPL_BAUD);
        wr(ADDR_RXFL, RXFL_OFF);
        rx_try(1'b0, 9'd2, 1'b1);
        wr(ADDR_RXFL, 8'h0A);
        rx_try(1'b0, 9'd10, 1'b0);
        rx_try(1'b0, 9'd30, 1'b1);
        wr(ADDR_EVCH, 8'h0B);
        rx_try(1'b0, 9'd30, 1'b0);
        rx_try(1'b1, 9'd30, 1'b1);
        wr(ADDR_EVCH, 8'h03);
        rx_try(1'b1, 9'd30, 1'b0);
        rx_try(1'b0, 9'd30, 1'b1);
        communication_mode_select_i <= 4'h0;
        tx_try(8'h05, 8'h00);
        end_of_test;
    end
endmodule : tb_infrared_pulse_codec
